/* verilog/timing_pin_pkg.sv */
// Package for the timing-signal pin selector: offsets, fields, codes and state types
package timing_pin_pkg;

	// Register offsets as printed
	localparam logic [7:0] OFS_PIN_OUTPUT_CONTROL = 8'h02;
	localparam logic [7:0] OFS_TIMING_SIGNAL_SELECT = 8'h0b;
	localparam logic [7:0] OFS_SECOND_PIN_DRIVE_ENABLE = 8'h4f;

	// Reset values
	localparam logic [15:0] RST_PIN_OUTPUT_CONTROL = 16'h0000;
	localparam logic [15:0] RST_TIMING_SIGNAL_SELECT = 16'h0000;
	localparam logic [15:0] RST_SECOND_PIN_DRIVE_ENABLE = 16'h0000;

	// Field positions in the pin output control register
	localparam int POS_POLARITY_FIRST = 0;
	localparam int POS_MODE_FIRST = 1;
	localparam int POS_ENABLE_FIRST = 2;
	localparam int POS_POLARITY_SECOND = 8;
	localparam int POS_MODE_SECOND = 9;
	// Field position in the second pin enable register
	localparam int POS_ENABLE_SECOND = 6;
	// Select fields
	localparam int POS_SEL_FIRST_LSB = 0;
	localparam int POS_SEL_SECOND_LSB = 8;
	localparam int SEL_WIDTH = 5;

	// Source select codes
	localparam logic [4:0] CODE_INTERRUPT = 5'h01;
	localparam logic [4:0] CODE_WINDOW = 5'h02;
	localparam logic [4:0] CODE_LED_A = 5'h05;
	localparam logic [4:0] CODE_LED_B = 5'h06;
	localparam logic [4:0] CODE_LED_AB = 5'h07;
	localparam logic [4:0] CODE_WRITTEN_A = 5'h0c;
	localparam logic [4:0] CODE_WRITTEN_B = 5'h0d;
	localparam logic [4:0] CODE_WRITTEN_AB = 5'h0e;
	localparam logic [4:0] CODE_HALF_RATE = 5'h0f;
	localparam logic [4:0] CODE_LOW = 5'h10;
	localparam logic [4:0] CODE_HIGH = 5'h11;
	localparam logic [4:0] CODE_OSC = 5'h13;

	// Internal timing sources, all active high before polarity
	typedef struct packed {
		logic irq;
		logic window;
		logic ledA;
		logic ledB;
		logic wrA;
		logic wrB;
		logic halfRate;
		logic osc;
	} sources_t;

	// Sequencer events feeding the selector
	typedef struct packed {
		logic slotAEn;
		logic slotBEn;
		logic slotAStart;
		logic slotAEnd;
		logic slotBStart;
		logic slotBEnd;
		logic sampleStart;
		logic sampleDone;
	} seq_t;

	// Whole state of the selector
	typedef struct packed {
		logic [15:0] ctrlReg;
		logic [15:0] selReg;
		logic [15:0] enReg;
		logic [15:0] rdData;
		logic windowActive;
		logic writtenA;
		logic writtenB;
		logic halfRate;
		logic opNormalPrev;
		logic oscMeta;
		logic oscSync;
		logic [1:0] pinMeta;
		logic [1:0] pinSync;
		logic [1:0] pinOut;
		logic [1:0] pinOeN;
	} state_t;

endpackage

/* verilog/timing_signal_gpio_select.sv */
// Timing-signal selector and pad control for the two general-purpose timing pins
module timing_signal_gpio_select (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic reset,
	// Register port from the serial interface core
	input wire logic regWrite,
	input wire logic regRead,
	input wire logic [7:0] regAddr,
	input wire logic [15:0] regWrData,
	output logic [15:0] regRdData,
	// Sequencer and core sources
	input wire timing_pin_pkg::seq_t seq,
	input wire logic irqMasked,
	input wire logic ledPulseA,
	input wire logic ledPulseB,
	input wire logic legacySampleOutput,
	input wire logic opNormal,
	input wire logic osc32k,
	// Timing pins: output, active-low enable, input
	output logic timingPinFirstOut,
	output logic timingPinFirstOeN,
	input wire logic timingPinFirstIn,
	output logic timingPinSecondOut,
	output logic timingPinSecondOeN,
	input wire logic timingPinSecondIn,
	// Synchronised pad levels
	output logic [1:0] pinSense
);

	// Two pins, each with its own source code, polarity, drive mode and enable
	// Everything but the pad inputs and the oscillator is on clk_sys already
	// Pad outputs are registered, so a source change shows one cycle later
	// Limitation: the oscillator copy is only as fine as clk_sys sampling
	// Limitation: sequencer pulses must be one clk_sys cycle wide
	// Interrupt masking is done upstream; only the masked level arrives
	timing_pin_pkg::state_t state_reg; // Registered state
	timing_pin_pkg::state_t state_next; // Next state
	timing_pin_pkg::sources_t src; // Current source levels
	logic legacy; // Select register all zero
	logic [1:0] act; // Selected signal, before polarity
	logic [1:0] pol; // Polarity bits
	logic [1:0] odMode; // Drive-when-asserted bits
	logic [1:0] pinEn; // Driver enables
	logic [4:0] selFirst; // First pin code
	logic [4:0] selSecond; // Second pin code

	// Map a select code to a source level; unknown codes stay inactive
	// One decode shared by both pins, so the two code tables cannot drift
	// Gaps in the code table fall to the default branch
	function automatic logic pick(input logic [4:0] code, input timing_pin_pkg::sources_t s);
		logic v;
		v = 1'b0; // Inactive level for undefined codes
		case (code)
			timing_pin_pkg::CODE_INTERRUPT: v = s.irq;
			timing_pin_pkg::CODE_WINDOW: v = s.window;
			timing_pin_pkg::CODE_LED_A: v = s.ledA;
			timing_pin_pkg::CODE_LED_B: v = s.ledB;
			timing_pin_pkg::CODE_LED_AB: v = s.ledA | s.ledB;
			timing_pin_pkg::CODE_WRITTEN_A: v = s.wrA;
			timing_pin_pkg::CODE_WRITTEN_B: v = s.wrB;
			timing_pin_pkg::CODE_WRITTEN_AB: v = s.wrA | s.wrB;
			timing_pin_pkg::CODE_HALF_RATE: v = s.halfRate;
			timing_pin_pkg::CODE_LOW: v = 1'b0;
			timing_pin_pkg::CODE_HIGH: v = 1'b1;
			timing_pin_pkg::CODE_OSC: v = s.osc;
			default: v = 1'b0;
		endcase
		return v;
	endfunction

	// Field extraction from the registers
	// Whole words are stored, fields are cut here
	// Second enable sits in its own register, not the control word
	always_comb begin
		selFirst = state_reg.selReg[timing_pin_pkg::POS_SEL_FIRST_LSB +: timing_pin_pkg::SEL_WIDTH];
		selSecond = state_reg.selReg[timing_pin_pkg::POS_SEL_SECOND_LSB +: timing_pin_pkg::SEL_WIDTH];
		legacy = (state_reg.selReg == 16'h0000);
		pol[0] = state_reg.ctrlReg[timing_pin_pkg::POS_POLARITY_FIRST];
		pol[1] = state_reg.ctrlReg[timing_pin_pkg::POS_POLARITY_SECOND];
		odMode[0] = state_reg.ctrlReg[timing_pin_pkg::POS_MODE_FIRST];
		odMode[1] = state_reg.ctrlReg[timing_pin_pkg::POS_MODE_SECOND];
		pinEn[0] = state_reg.ctrlReg[timing_pin_pkg::POS_ENABLE_FIRST];
		pinEn[1] = state_reg.enReg[timing_pin_pkg::POS_ENABLE_SECOND];
	end

	// Source levels; the interrupt is already gated by the host's mask choice
	// Flags come from the state, pulse copies pass straight through
	// Pulse copies gain one flop of delay at the pad register
	always_comb begin
		src.irq = irqMasked;
		src.window = state_reg.windowActive;
		src.ledA = ledPulseA;
		src.ledB = ledPulseB;
		src.wrA = state_reg.writtenA;
		src.wrB = state_reg.writtenB;
		src.halfRate = state_reg.halfRate;
		src.osc = state_reg.oscSync;
	end

	// Each pin decodes its own field, so one source may feed both
	// Legacy mode takes over only when the whole word is zero
	// A single zero field is just an undefined code
	// Pad polarity, mode and enable still apply in legacy mode
	always_comb begin
		if (legacy) begin
			act[0] = irqMasked; // Legacy interrupt pin
			act[1] = legacySampleOutput; // Legacy sample output pin
		end else begin
			act[0] = pick(selFirst, src);
			act[1] = pick(selSecond, src);
		end
	end

	// Next-state logic
	// One process computes every flag; set beats clear on a shared edge, except that the half-rate restart beats a toggle
	// Locals cleared first so no latch is inferred
	always_comb begin
		logic windowStart;
		logic windowEnd;
		logic restart;
		windowStart = 1'b0;
		windowEnd = 1'b0;
		restart = 1'b0;
		state_next = state_reg;

		// Register writes; whole words kept so other fields read back
		// A write to an unmapped offset is dropped silently
		// New settings reach the pads two edges after the write
		if (regWrite) begin
			case (regAddr)
				timing_pin_pkg::OFS_PIN_OUTPUT_CONTROL: state_next.ctrlReg = regWrData;
				timing_pin_pkg::OFS_TIMING_SIGNAL_SELECT: state_next.selReg = regWrData;
				timing_pin_pkg::OFS_SECOND_PIN_DRIVE_ENABLE: state_next.enReg = regWrData;
				default: state_next.ctrlReg = state_reg.ctrlReg;
			endcase
		end

		// Read data held until the next read; unmapped reads as zero
		// Read and write on one edge: the read sees the old word
		// Registered read keeps the decode off the bus timing path
		if (regRead) begin
			case (regAddr)
				timing_pin_pkg::OFS_PIN_OUTPUT_CONTROL: state_next.rdData = state_reg.ctrlReg;
				timing_pin_pkg::OFS_TIMING_SIGNAL_SELECT: state_next.rdData = state_reg.selReg;
				timing_pin_pkg::OFS_SECOND_PIN_DRIVE_ENABLE: state_next.rdData = state_reg.enReg;
				default: state_next.rdData = 16'h0000;
			endcase
		end

		// Window opens at first enabled slot, closes at last one
		// Start beats end when both land in one cycle
		// Disabled slots are ignored, so one enabled slot spans itself
		windowStart = seq.slotAEn ? seq.slotAStart : (seq.slotBEn & seq.slotBStart);
		windowEnd = seq.slotBEn ? seq.slotBEnd : (seq.slotAEn & seq.slotAEnd);
		if (windowStart) begin
			state_next.windowActive = 1'b1;
		end else if (windowEnd) begin
			state_next.windowActive = 1'b0;
		end

		// Written flags: slot end sets, next sample start clears, set wins
		// Flags stay up through the sleep period until the next sample
		// A disabled slot never raises its flag
		if (seq.slotAEnd && seq.slotAEn) begin
			state_next.writtenA = 1'b1;
		end else if (seq.sampleStart) begin
			state_next.writtenA = 1'b0;
		end
		if (seq.slotBEnd && seq.slotBEn) begin
			state_next.writtenB = 1'b1;
		end else if (seq.sampleStart) begin
			state_next.writtenB = 1'b0;
		end

		// Half-rate toggle restarts low on entering normal mode
		// Rising edge of the normal-mode level marks standby to normal
		// Frozen outside normal mode; restart wins over a same-cycle sample end
		restart = opNormal & ~state_reg.opNormalPrev;
		state_next.opNormalPrev = opNormal;
		if (restart) begin
			state_next.halfRate = 1'b0;
		end else if (seq.sampleDone && opNormal) begin
			state_next.halfRate = ~state_reg.halfRate;
		end

		// Oscillator and pad inputs come from other domains
		// Two flops each; logic reads only the second
		// Trade-off: three cycles of lag on the oscillator copy
		// Acceptable, as clk_sys is far faster than the oscillator
		state_next.oscMeta = osc32k;
		state_next.oscSync = state_reg.oscMeta;
		state_next.pinMeta = {timingPinSecondIn, timingPinFirstIn};
		state_next.pinSync = state_reg.pinMeta;

		// Pad drive: polarity on level, release when disabled or idle in open-drain
		// Drive-when-asserted looks at the level before polarity
		// A released pad relies on an outside pull to settle
		for (int i = 0; i < 2; i++) begin
			state_next.pinOut[i] = act[i] ^ pol[i];
			state_next.pinOeN[i] = ~(pinEn[i] & (~odMode[i] | act[i]));
		end
	end

	// State register, synchronous reset
	// Reset releases both pads and clears every register
	// Cleared select word means legacy mode right after reset
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			state_reg <= '{
				ctrlReg: timing_pin_pkg::RST_PIN_OUTPUT_CONTROL,
				selReg: timing_pin_pkg::RST_TIMING_SIGNAL_SELECT,
				enReg: timing_pin_pkg::RST_SECOND_PIN_DRIVE_ENABLE,
				rdData: 16'h0000,
				windowActive: 1'b0,
				writtenA: 1'b0,
				writtenB: 1'b0,
				halfRate: 1'b0,
				opNormalPrev: 1'b0,
				oscMeta: 1'b0,
				oscSync: 1'b0,
				pinMeta: 2'h0,
				pinSync: 2'h0,
				pinOut: 2'h0,
				pinOeN: 2'h3
			};
		end else begin
			state_reg <= state_next;
		end
	end

	// Outputs straight from flops
	// No logic between the flops and the pads, so no glitches
	// Shared open-drain lines need that for clean edges
	assign regRdData = state_reg.rdData;
	assign timingPinFirstOut = state_reg.pinOut[0];
	assign timingPinFirstOeN = state_reg.pinOeN[0];
	assign timingPinSecondOut = state_reg.pinOut[1];
	assign timingPinSecondOeN = state_reg.pinOeN[1];
	assign pinSense = state_reg.pinSync;

	// Checks on the pad and timing logic
	// Checks use |=> because every output is one flop behind
	// All of them are off while reset is high
	// Routing checks assume polarity clear unless stated
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (reset);

	a_pol_invert_high: assert property ((!legacy && selFirst == timing_pin_pkg::CODE_HIGH && pol[0])
		|=> !timingPinFirstOut)
		else $error("inverted constant high not low");
	a_od_release_idle: assert property ((pinEn[1] && odMode[1] && !act[1]) |=> timingPinSecondOeN)
		else $error("open-drain pin driven while idle");
	a_pushpull_drive: assert property ((pinEn[0] && !odMode[0]) |=> !timingPinFirstOeN)
		else $error("push-pull pin not driven");
	a_first_disabled: assert property (!pinEn[0] |=> timingPinFirstOeN)
		else $error("first pin driven while disabled");
	a_second_disabled: assert property (!state_reg.enReg[timing_pin_pkg::POS_ENABLE_SECOND]
		|=> timingPinSecondOeN)
		else $error("second pin driven while disabled");
	a_legacy_irq_route: assert property ((legacy && !pol[0]) |=> timingPinFirstOut == $past(irqMasked))
		else $error("legacy mode lost interrupt");
	a_window_open: assert property ((seq.slotAEn && seq.slotAStart) |=> state_reg.windowActive)
		else $error("window did not open");
	a_window_single: assert property ((!seq.slotBEn && seq.slotAEn && seq.slotAEnd && !seq.slotAStart)
		|=> !state_reg.windowActive)
		else $error("single slot window did not close");
	a_written_hold: assert property ((state_reg.writtenA && !seq.sampleStart) |=> state_reg.writtenA)
		else $error("written flag dropped early");
	a_written_set_wins: assert property ((seq.slotBEnd && seq.slotBEn && seq.sampleStart)
		|=> state_reg.writtenB)
		else $error("written set lost to clear");
	a_half_restart: assert property ((opNormal && !state_reg.opNormalPrev) |=> !state_reg.halfRate)
		else $error("half-rate not restarted low");
	a_half_toggle: assert property ((opNormal && state_reg.opNormalPrev && seq.sampleDone)
		|=> state_reg.halfRate != $past(state_reg.halfRate))
		else $error("half-rate did not toggle");
	a_undef_idle: assert property ((!legacy && selFirst == 5'h03) |=> timingPinFirstOut == $past(pol[0]))
		else $error("undefined code not idle");
	a_low_const: assert property ((!legacy && selSecond == timing_pin_pkg::CODE_LOW && !pol[1])
		|=> !timingPinSecondOut)
		else $error("constant low not low");

	// Interrupt on the second pin follows the masked level
	a_irq_second: assert property ((!legacy && selSecond == timing_pin_pkg::CODE_INTERRUPT && !pol[1])
		|=> timingPinSecondOut == $past(irqMasked))
		else $error("interrupt not routed to second pin");
	// Window flag reaches the first pin
	a_window_route: assert property ((!legacy && selFirst == timing_pin_pkg::CODE_WINDOW && !pol[0])
		|=> timingPinFirstOut == $past(state_reg.windowActive))
		else $error("window not routed to first pin");
	// Both slots on: window closes at the end of slot B
	a_window_close: assert property ((seq.slotAEn && seq.slotBEn && seq.slotBEnd && !seq.slotAStart)
		|=> !state_reg.windowActive)
		else $error("window open after last slot");
	// Merged LED pulses on the first pin
	a_led_both: assert property ((!legacy && selFirst == timing_pin_pkg::CODE_LED_AB && !pol[0])
		|=> timingPinFirstOut == $past(ledPulseA | ledPulseB))
		else $error("merged LED pulses not copied");
	// Slot A LED pulses on the second pin
	a_led_a_copy: assert property ((!legacy && selSecond == timing_pin_pkg::CODE_LED_A && !pol[1])
		|=> timingPinSecondOut == $past(ledPulseA))
		else $error("slot A LED pulses not copied");
	// Either-slot written flag on the second pin
	a_written_any: assert property ((!legacy && selSecond == timing_pin_pkg::CODE_WRITTEN_AB && !pol[1])
		|=> timingPinSecondOut == $past(state_reg.writtenA | state_reg.writtenB))
		else $error("either-slot written flag not routed");
	// Slot end raises the written flag
	a_written_set: assert property ((seq.slotAEnd && seq.slotAEn) |=> state_reg.writtenA)
		else $error("written flag not set at slot end");
	// Sample start drops the written flag
	a_written_clear: assert property ((seq.sampleStart && !(seq.slotAEnd && seq.slotAEn))
		|=> !state_reg.writtenA)
		else $error("written flag not cleared at sample start");
	// Half-rate holds between sample ends
	a_half_hold: assert property ((opNormal && state_reg.opNormalPrev && !seq.sampleDone)
		|=> $stable(state_reg.halfRate))
		else $error("half-rate moved without a sample");
	// Constant high on the first pin
	a_high_const: assert property ((!legacy && selFirst == timing_pin_pkg::CODE_HIGH && !pol[0])
		|=> timingPinFirstOut)
		else $error("constant high not high");
	// Oscillator copy after the synchroniser
	a_osc_copy: assert property ((!legacy && selFirst == timing_pin_pkg::CODE_OSC && !pol[0])
		|=> timingPinFirstOut == $past(state_reg.oscSync))
		else $error("oscillator not copied");
	// Second field drives the second pin with its own polarity
	a_second_field: assert property ((!legacy && selSecond == timing_pin_pkg::CODE_HIGH)
		|=> timingPinSecondOut == !$past(pol[1]))
		else $error("second select field ignored");
	// Drive-when-asserted pin is driven while asserted
	a_od_drive_on: assert property ((pinEn[0] && odMode[0] && act[0]) |=> !timingPinFirstOeN)
		else $error("open-drain pin not driven while asserted");
	// One source on both pins gives equal levels
	a_same_source: assert property ((!legacy && selFirst == selSecond && pol[0] == pol[1])
		|=> timingPinFirstOut == timingPinSecondOut)
		else $error("shared source differs between pins");

	c_legacy_mode: cover property (legacy && pinEn[0]);
	c_both_same_src: cover property (!legacy && selFirst == selSecond && selFirst == timing_pin_pkg::CODE_WINDOW);
	c_half_rise: cover property (!state_reg.halfRate ##1 state_reg.halfRate);
	c_od_pulse: cover property (pinEn[1] && odMode[1] && act[1]);
	c_set_beats_clear: cover property (seq.slotBEn && seq.slotBEnd && seq.sampleStart);

endmodule

/* testbench/timing_pin_partner.sv */
// Far-side peripheral model: pull-ups on the shared timing lines
module timing_pin_partner (
	// Pad drivers from the device
	input wire logic firstOut,
	input wire logic firstOeN,
	input wire logic secondOut,
	input wire logic secondOeN,
	// Resolved line levels seen by everyone
	output logic firstLine,
	output logic secondLine
);
	timeunit 1ns;
	timeprecision 1ns;
	// A released line floats up, so open-drain idles high
	assign firstLine = firstOeN ? 1'b1 : firstOut;
	assign secondLine = secondOeN ? 1'b1 : secondOut;
endmodule

/* testbench/timing_signal_gpio_select_tb.sv */
// Self-checking bench for the timing-signal pin selector
module timing_signal_gpio_select_tb;
	timeunit 1ns;
	timeprecision 1ns;
	// Short names for the register offsets
	localparam logic [7:0] CTL = timing_pin_pkg::OFS_PIN_OUTPUT_CONTROL;
	localparam logic [7:0] SEL = timing_pin_pkg::OFS_TIMING_SIGNAL_SELECT;
	localparam logic [7:0] ENA = timing_pin_pkg::OFS_SECOND_PIN_DRIVE_ENABLE;
	// Stimulus, all given a value at time zero
	logic clk_sys = 1'b0;
	logic reset = 1'b1;
	logic regWrite = 1'b0;
	logic regRead = 1'b0;
	logic [7:0] regAddr = 8'h00;
	logic [15:0] regWrData = 16'h0000;
	timing_pin_pkg::seq_t seq = '0;
	logic irqMasked = 1'b0;
	logic ledPulseA = 1'b0;
	logic ledPulseB = 1'b0;
	logic legacySampleOutput = 1'b0;
	logic opNormal = 1'b0;
	logic osc32k = 1'b0;
	// Observed outputs
	logic [15:0] regRdData;
	logic firstOut, firstOeN, secondOut, secondOeN, firstLine, secondLine;
	logic [1:0] pinSense;
	// Bookkeeping
	int miscompares = 0;
	int cmp_count = 0;
	int cycles = 0;
	// Defined and undefined select codes swept on both pins
	logic [4:0] codes [12] = '{5'h01, 5'h05, 5'h06, 5'h07, 5'h10, 5'h11, 5'h03, 5'h08, 5'h0b, 5'h12, 5'h14, 5'h1f};

	timing_signal_gpio_select i_dut (.clk_sys(clk_sys), .reset(reset), .regWrite(regWrite), .regRead(regRead),
		.regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData), .seq(seq), .irqMasked(irqMasked),
		.ledPulseA(ledPulseA), .ledPulseB(ledPulseB), .legacySampleOutput(legacySampleOutput),
		.opNormal(opNormal), .osc32k(osc32k), .timingPinFirstOut(firstOut), .timingPinFirstOeN(firstOeN),
		.timingPinFirstIn(firstLine), .timingPinSecondOut(secondOut), .timingPinSecondOeN(secondOeN),
		.timingPinSecondIn(secondLine), .pinSense(pinSense));
	timing_pin_partner i_partner (.firstOut(firstOut), .firstOeN(firstOeN), .secondOut(secondOut),
		.secondOeN(secondOeN), .firstLine(firstLine), .secondLine(secondLine));

	// 20 MHz clock
	always #25 clk_sys = ~clk_sys;

	// Hang guard, far above the few hundred cycles the run needs
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 3000) begin
			miscompares++;
			end_of_test();
		end
	end

	// Value compare
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		cmp_count++;
		if (got !== exp) begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask
	// Pad state as {firstOut, firstOeN, secondOut, secondOeN}
	task automatic pins(input logic [3:0] exp);
		chk("pins", {12'h000, exp}, {12'h000, firstOut, firstOeN, secondOut, secondOeN});
	endtask
	// One-cycle write strobe; returns once the pins show the new setting
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(negedge clk_sys);
		regWrite = 1'b1;
		regAddr = a;
		regWrData = d;
		@(negedge clk_sys);
		regWrite = 1'b0;
		@(negedge clk_sys);
	endtask
	// One-cycle read strobe; data is registered one cycle later
	task automatic rd(input logic [7:0] a, input logic [15:0] exp);
		@(negedge clk_sys);
		regRead = 1'b1;
		regAddr = a;
		@(negedge clk_sys);
		regRead = 1'b0;
		chk("read", exp, regRdData);
	endtask
	// One-cycle sequencer pulse; flags reach the pins two cycles on
	task automatic ev(input logic [7:0] p);
		@(negedge clk_sys);
		seq = timing_pin_pkg::seq_t'(seq | p);
		@(negedge clk_sys);
		seq = timing_pin_pkg::seq_t'(seq & ~p);
		@(negedge clk_sys);
	endtask
	// Expected active-high source for a select code
	function automatic logic srcOf(input logic [4:0] c);
		case (c)
			5'h01: return irqMasked;
			5'h05: return ledPulseA;
			5'h06: return ledPulseB;
			5'h07: return ledPulseA | ledPulseB;
			5'h11: return 1'b1;
			default: return 1'b0;
		endcase
	endfunction
	// Counts, verdict and stop
	task automatic end_of_test();
		$display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	// Main sequence
	initial begin
		repeat (12) @(negedge clk_sys);
		reset = 1'b0;
		pins(4'b0101);
		rd(CTL, timing_pin_pkg::RST_PIN_OUTPUT_CONTROL);
		rd(SEL, timing_pin_pkg::RST_TIMING_SIGNAL_SELECT);
		rd(ENA, timing_pin_pkg::RST_SECOND_PIN_DRIVE_ENABLE);
		// Unmapped place reads zero and swallows writes
		wr(8'h31, 16'h1234);
		rd(8'h31, 16'h0000);
		rd(SEL, 16'h0000);
		wr(CTL, 16'hffff);
		rd(CTL, 16'hffff);
		// Independent constant sources per pin
		wr(SEL, 16'h1011);
		rd(SEL, 16'h1011);
		wr(ENA, 16'h0040);
		rd(ENA, 16'h0040);
		wr(CTL, 16'h0004);
		pins(4'b1000);
		wr(CTL, 16'h0105);
		pins(4'b0010);
		wr(CTL, 16'h0206);
		pins(4'b1001);
		wr(ENA, 16'h0000);
		wr(CTL, 16'h0000);
		pins(4'b1101);
		repeat (2) @(negedge clk_sys);
		chk("sense", 16'h0003, {14'h0000, pinSense});
		wr(CTL, 16'h0004);
		wr(ENA, 16'h0040);
		// Each of the twelve listed codes on both pins, two source patterns
		for (int k = 0; k < 24; k++) begin
			{irqMasked, ledPulseA, ledPulseB} = (k < 12) ? 3'b101 : 3'b010;
			wr(SEL, {3'b000, codes[k % 12], 3'b000, codes[k % 12]});
			pins({srcOf(codes[k % 12]), 1'b0, srcOf(codes[k % 12]), 1'b0});
		end
		chk("sense", 16'h0000, {14'h0000, pinSense});
		// Legacy mapping with the whole select register clear
		wr(SEL, 16'h0000);
		irqMasked = 1'b1;
		legacySampleOutput = 1'b0;
		repeat (2) @(negedge clk_sys);
		pins(4'b1000);
		irqMasked = 1'b0;
		legacySampleOutput = 1'b1;
		repeat (2) @(negedge clk_sys);
		pins(4'b0010);
		// Window on first pin, either-slot written flag on second
		wr(SEL, 16'h0e02);
		seq.slotAEn = 1'b1;
		seq.slotBEn = 1'b1;
		ev(8'h20);
		pins(4'b1000);
		ev(8'h10);
		pins(4'b1010);
		ev(8'h08);
		ev(8'h04);
		pins(4'b0010);
		ev(8'h02);
		pins(4'b0000);
		// Slot B alone, slot B written flag
		seq.slotAEn = 1'b0;
		wr(SEL, 16'h0d02);
		ev(8'h08);
		pins(4'b1000);
		ev(8'h04);
		pins(4'b0010);
		// Slot A alone, slot A written flag
		seq.slotAEn = 1'b1;
		seq.slotBEn = 1'b0;
		wr(SEL, 16'h0c02);
		ev(8'h20);
		pins(4'b1000);
		ev(8'h10);
		pins(4'b0010);
		// Slot A written flag against slot B code; set beats a same-cycle clear
		seq.slotBEn = 1'b1;
		wr(SEL, 16'h0c0d);
		ev(8'h02);
		ev(8'h10);
		pins(4'b0010);
		ev(8'h06);
		pins(4'b1000);
		// Half-rate toggle and its restart
		wr(SEL, 16'h100f);
		opNormal = 1'b1;
		repeat (3) @(negedge clk_sys);
		pins(4'b0000);
		ev(8'h01);
		pins(4'b1000);
		ev(8'h01);
		pins(4'b0000);
		ev(8'h01);
		opNormal = 1'b0;
		@(negedge clk_sys);
		opNormal = 1'b1;
		repeat (3) @(negedge clk_sys);
		pins(4'b0000);
		// Oscillator copy through the synchroniser
		wr(SEL, 16'h1013);
		osc32k = 1'b1;
		repeat (4) @(negedge clk_sys);
		pins(4'b1000);
		osc32k = 1'b0;
		repeat (4) @(negedge clk_sys);
		pins(4'b0000);
		end_of_test();
	end
endmodule
